// file: src/flash_prot_map.svh
// Purpose: offsets, field positions, reset values of flash protection block
// Assumes: apb byte addresses, one register per word
// Notes:   definitions only
`ifndef FLASH_PROT_MAP_SVH
`define FLASH_PROT_MAP_SVH
`define SEC_OFFSET        12'h000
`define CFG_OFFSET        12'h008
`define PROT_OFFSET       12'h004
`define STAT_OFFSET       12'h00c
`define CMD_OFFSET        12'h010
`define CFG_BE_IE_BIT     7
`define CFG_CD_IE_BIT     6
`define CFG_KEY_BIT       5
`define PROT_POL_BIT      7
`define PROT_SPARE_BIT    6
`define PROT_UDIS_BIT     5
`define PROT_LDIS_BIT     2
`define STAT_BE_BIT       7
`define STAT_CD_BIT       6
`define STAT_PV_BIT       5
`define KEY_ENABLED       2'b10
`define CFG_RESET         8'h00
`define LOW_BASE          16'h4000
`define LOW_SIZE_MIN      16'h0200
`define HIGH_SIZE_MIN     16'h0800
`define NVM_PROT_ADDR     16'hff0d
`endif

// file: src/flash_prot_pkg.sv
// Purpose: types of the flash protection block
// Assumes: nothing
// Notes:   constants live in flash_prot_map.svh
package flash_prot_pkg;
   typedef enum logic [1:0] {
      CMD_PROGRAM    = 2'b00,
      CMD_SECT_ERASE = 2'b01,
      CMD_MASS_ERASE = 2'b10,
      CMD_NONE       = 2'b11
   } cmd_kind_type;

   typedef struct packed {
      logic        be_ie;
      logic        cd_ie;
      logic        key_gate;
   } cfg_type;

   typedef struct packed {
      logic        pol;
      logic        spare;
      logic        udis;
      logic [1:0]  usize;
      logic        ldis;
      logic [1:0]  lsize;
   } prot_type;

   typedef struct packed {
      cfg_type     cfg;
      prot_type    prot;
      logic        loaded;
      logic        protection_violation_flag;
      logic        be_flag;
      logic        cd_flag;
      logic        irq;
      logic        pready;
      logic [31:0] prdata;
      logic        cmd_ok;
      logic        cmd_rej;
   } state_type;
endpackage

// file: src/flash_prot_cfg.sv
// Purpose: configuration and protection registers of a flash controller
// Assumes: apb slave, protection byte presented at reset release
// Notes:   one wait state on every access
`timescale 1ns/100ps
`include "flash_prot_map.svh"

module flash_prot_cfg
   import flash_prot_pkg::*;
(
   input  wire logic         mclk_in,
   input  wire logic         rst_b_in,
   input  wire logic         psel_in,
   input  wire logic         penable_in,
   input  wire logic         pwrite_in,
   input  wire logic [11:0]  paddr_in,
   input  wire logic [31:0]  pwdata_in,
   input  wire logic [7:0]   nvm_prot_byte_in,
   input  wire logic [7:0]   security_register_in,
   input  wire logic         buffer_empty_set_in,
   input  wire logic         command_done_set_in,
   input  wire logic         cmd_valid_in,
   input  wire cmd_kind_type cmd_kind_in,
   input  wire logic [15:0]  cmd_addr_in,
   output logic              pready_out,
   output logic [31:0]       prdata_out,
   output logic              pslverr_out,
   output logic              irq_out,
   output logic              key_write_mode_out,
   output logic              cmd_accept_out,
   output logic              cmd_reject_out
);
   state_type s_r;
   state_type s_nxt;

   // scenario number: polarity, upper disable, lower disable
   function automatic logic [2:0] scen(input prot_type p);
      scen = {p.pol, p.udis, p.ldis};
   endfunction

   // legal scenario transitions, protection may only be added from idx 0 to 3; rows 4 to 7 also allow less
   function automatic logic allowed(input logic [2:0] f,
                                    input logic [2:0] t);
      logic [7:0] row;
      row = 8'h00;
      unique case (f)
         3'd0: row = 8'h0f;
         3'd1: row = 8'h0a;
         3'd2: row = 8'h0c;
         3'd3: row = 8'h08;
         3'd4: row = 8'h18;
         3'd5: row = 8'h3c;
         3'd6: row = 8'h5a;
         3'd7: row = 8'hff;
      endcase
      allowed = row[t];
   endfunction

   // scenario index from table order above
   function automatic logic [2:0] idx(input prot_type p);
      logic [2:0] k;
      k = scen(p);
      unique case (k)
         3'b111: idx = 3'd0;
         3'b110: idx = 3'd1;
         3'b101: idx = 3'd2;
         3'b100: idx = 3'd3;
         3'b011: idx = 3'd4;
         3'b001: idx = 3'd5;
         3'b010: idx = 3'd6;
         3'b000: idx = 3'd7;
      endcase
   endfunction

   function automatic logic in_low(input prot_type p,
                                   input logic [15:0] a);
      logic [15:0] sz;
      sz = 16'(`LOW_SIZE_MIN << p.lsize);
      in_low = (a >= `LOW_BASE) && (a < 16'(`LOW_BASE + sz));
   endfunction

   function automatic logic in_high(input prot_type p,
                                    input logic [15:0] a);
      logic [15:0] sz;
      sz = 16'(`HIGH_SIZE_MIN << p.usize);
      in_high = a >= 16'(17'h10000 - {1'b0, sz});
   endfunction

   function automatic logic is_prot(input prot_type p,
                                    input logic [15:0] a);
      logic lo;
      logic hi;
      lo = !p.ldis && in_low(p, a);
      hi = !p.udis && in_high(p, a);
      if (p.pol)
         is_prot = lo || hi;
      else if (p.udis && p.ldis)
         is_prot = 1'b1;
      else
         is_prot = !(lo || hi);
   endfunction

   // word returned for a read of the given offset
   function automatic logic [31:0] read_word(input state_type   s,
                                             input logic [11:0] a,
                                             input logic [7:0]  sec);
      logic [31:0] w;
      w = 32'h0;
      unique case (a)
         `CFG_OFFSET: begin
            w[`CFG_BE_IE_BIT] = s.cfg.be_ie;
            w[`CFG_CD_IE_BIT] = s.cfg.cd_ie;
            w[`CFG_KEY_BIT] = s.cfg.key_gate;
         end
         `PROT_OFFSET: begin
            w[7:0] = s.prot;
         end
         `SEC_OFFSET: begin
            w[7:0] = sec;
         end
         `STAT_OFFSET: begin
            w[`STAT_BE_BIT] = s.be_flag;
            w[`STAT_CD_BIT] = s.cd_flag;
            w[`STAT_PV_BIT] = s.protection_violation_flag;
         end
         default: begin
            w = 32'h0;
         end
      endcase
      read_word = w;
   endfunction

   // frozen size fields keep their value, polarity only falls
   function automatic prot_type merge(input prot_type cur,
                                      input prot_type w);
      prot_type c;
      c = cur;
      c.pol = cur.pol & w.pol;
      c.spare = w.spare;
      c.udis = w.udis;
      c.ldis = w.ldis;
      // size follows the write only while its range is disabled
      if (cur.udis) begin
         c.usize = w.usize;
      end
      if (cur.ldis) begin
         c.lsize = w.lsize;
      end
      merge = c;
   endfunction

   // mass erase needs every range open
   function automatic logic mass_ok(input prot_type p);
      mass_ok = p.pol && p.udis && p.ldis;
   endfunction

   // request level from the next flags and enables
   function automatic logic irq_of(input state_type s);
      logic be;
      logic cd;
      be = s.cfg.be_ie && s.be_flag;
      cd = s.cfg.cd_ie && s.cd_flag;
      irq_of = be || cd;
   endfunction

   // bus decode and command qualifiers
   logic     setup_acc;
   logic     done;
   logic     wr;
   logic     hit_prot;
   logic     hit_cfg;
   logic     hit_stat;
   prot_type wp;
   prot_type cand;
   logic     cmd_live;
   logic     viol;

   always_comb begin
      s_nxt = s_r;
      // access phase seen while ready still low: answer next edge
      setup_acc = psel_in && penable_in && !s_r.pready;
      // completing edge: ready sampled high with the request held
      done = psel_in && penable_in && s_r.pready;
      wr = done && pwrite_in;
      hit_prot = (paddr_in == `PROT_OFFSET);
      hit_cfg = (paddr_in == `CFG_OFFSET);
      hit_stat = (paddr_in == `STAT_OFFSET);
      wp = prot_type'(pwdata_in[7:0]);
      cand = merge(s_r.prot, wp);
      cmd_live = cmd_valid_in && (cmd_kind_in != CMD_NONE)
                 && !s_r.cfg.key_gate && s_r.loaded;
      viol = 1'b0;
      s_nxt.pready = setup_acc;
      s_nxt.cmd_ok = 1'b0;
      s_nxt.cmd_rej = 1'b0;

      if (!s_r.loaded) begin
         // strap caught on the first clock after reset release
         s_nxt.prot = prot_type'(nvm_prot_byte_in);
         s_nxt.loaded = 1'b1;
      end

      // read word captured early so it stands with ready
      if (setup_acc && !pwrite_in) begin
         s_nxt.prdata = read_word(s_r, paddr_in, security_register_in);
      end

      if (wr && hit_cfg) begin
         s_nxt.cfg.be_ie = pwdata_in[`CFG_BE_IE_BIT];
         s_nxt.cfg.cd_ie = pwdata_in[`CFG_CD_IE_BIT];
         // key gate moves only while backdoor access is enabled
         if (security_register_in[7:6] == `KEY_ENABLED) begin
            s_nxt.cfg.key_gate = pwdata_in[`CFG_KEY_BIT];
         end
      end

      // writes before the strap load are dropped; bad scenario drops all
      if (wr && hit_prot && s_r.loaded) begin
         if (allowed(idx(s_r.prot), idx(cand))) begin
            s_nxt.prot = cand;
         end
      end

      // write one clears; hardware set wins over clear
      if (wr && hit_stat) begin
         if (pwdata_in[`STAT_BE_BIT]) begin
            s_nxt.be_flag = 1'b0;
         end
         if (pwdata_in[`STAT_PV_BIT]) begin
            s_nxt.protection_violation_flag = 1'b0;
         end
         if (pwdata_in[`STAT_CD_BIT]) begin
            s_nxt.cd_flag = 1'b0;
         end
      end

      if (buffer_empty_set_in) begin
         s_nxt.be_flag = 1'b1;
      end
      if (command_done_set_in) begin
         s_nxt.cd_flag = 1'b1;
      end

      // key mode commands never reach protection checks
      if (cmd_live) begin
         if (cmd_kind_in == CMD_MASS_ERASE) begin
            viol = !mass_ok(s_r.prot);
         end else begin
            viol = is_prot(s_r.prot, cmd_addr_in);
         end
         s_nxt.cmd_ok = !viol;
         s_nxt.cmd_rej = viol;
         if (viol) begin
            s_nxt.protection_violation_flag = 1'b1;
         end
      end

      // irq follows next-state flags, so no extra cycle of lag
      s_nxt.irq = irq_of(s_nxt);
   end

   // one register stage holds every bit of state
   always_ff @(posedge mclk_in) begin
      if (!rst_b_in) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign pready_out = s_r.pready;
   assign prdata_out = s_r.prdata;
   // no error response: unmapped reads give zero
   assign pslverr_out = 1'b0;
   assign irq_out = s_r.irq;
   assign key_write_mode_out = s_r.cfg.key_gate;
   assign cmd_accept_out = s_r.cmd_ok;
   assign cmd_reject_out = s_r.cmd_rej;
endmodule

// file: bench/flash_prot_chk.sv
// Purpose: port checks for flash_prot_cfg
// Assumes: one clock, sync active-low reset
// Notes:   bound to every instance
`timescale 1ns/100ps
`include "flash_prot_map.svh"
module flash_prot_chk
   import flash_prot_pkg::*;
(
   input wire logic         mclk_in,
   input wire logic         rst_b_in,
   input wire logic         psel_in,
   input wire logic         penable_in,
   input wire logic         pwrite_in,
   input wire logic [11:0]  paddr_in,
   input wire logic [31:0]  pwdata_in,
   input wire logic [7:0]   security_register_in,
   input wire logic         buffer_empty_set_in,
   input wire logic         command_done_set_in,
   input wire logic         cmd_valid_in,
   input wire cmd_kind_type cmd_kind_in,
   input wire logic         pready_out,
   input wire logic         irq_out,
   input wire logic         key_write_mode_out,
   input wire logic         cmd_accept_out,
   input wire logic         cmd_reject_out
);
   default clocking @(posedge mclk_in); endclocking
   default disable iff (!rst_b_in);
   wire logic wr = psel_in & penable_in & pwrite_in;
   wire logic cw = wr & (paddr_in == `CFG_OFFSET);
   wire logic kw = cw & (security_register_in[7:6] == `KEY_ENABLED);
   wire logic sw = wr & (paddr_in == `STAT_OFFSET);
   wire logic ev = buffer_empty_set_in | command_done_set_in | cw | sw;
   property p_ready;
      psel_in && penable_in && !pready_out |=> pready_out;
   endproperty
   a_ready: assert property (p_ready) else $error("no ready");
   property p_pulse;
      pready_out |=> !pready_out;
   endproperty
   a_pulse: assert property (p_pulse) else $error("ready held");
   property p_cmd;
      cmd_valid_in && cmd_kind_in != CMD_NONE && !key_write_mode_out
         |=> cmd_accept_out != cmd_reject_out;
   endproperty
   a_cmd: assert property (p_cmd) else $error("no verdict");
   property p_quiet;
      cmd_valid_in && key_write_mode_out
         |=> !cmd_accept_out && !cmd_reject_out;
   endproperty
   a_quiet: assert property (p_quiet) else $error("key cmd seen");
   property p_cause;
      cmd_accept_out || cmd_reject_out |-> $past(cmd_valid_in);
   endproperty
   a_cause: assert property (p_cause) else $error("stray verdict");
   property p_key;
      $changed(key_write_mode_out) |-> $past(kw) || $past(kw, 2);
   endproperty
   a_key: assert property (p_key) else $error("key gate moved");
   property p_irq;
      $changed(irq_out) |-> ev || $past(ev);
   endproperty
   a_irq: assert property (p_irq) else $error("irq moved");
   // both enables off must silence the request within two cycles of the write
   property p_mask;
      cw && pwdata_in[7:6] == 2'b00 |-> ##[1:2] !irq_out;
   endproperty
   a_mask: assert property (p_mask) else $error("irq unmasked");
endmodule

bind flash_prot_cfg flash_prot_chk chk_u (.mclk_in, .rst_b_in, .psel_in,
   .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .security_register_in,
   .buffer_empty_set_in, .command_done_set_in, .cmd_valid_in, .cmd_kind_in,
   .pready_out, .irq_out, .key_write_mode_out, .cmd_accept_out,
   .cmd_reject_out);

// file: bench/tb_flash_protection_config.sv
// Purpose: register and command tests of flash_prot_cfg
// Assumes: one wait state apb slave
// Notes:   commands checked one cycle after valid
`timescale 1ns/100ps
`include "flash_prot_map.svh"
module tb_flash_protection_config;
   import flash_prot_pkg::*;
   logic         mclk_in = 0, rst_b_in = 0, psel_in = 0, penable_in = 0;
   logic         pwrite_in = 0, buffer_empty_set_in = 0;
   logic         command_done_set_in = 0, cmd_valid_in = 0;
   logic [11:0]  paddr_in = 0;
   logic [31:0]  pwdata_in = 0, prdata_out;
   logic [7:0]   nvm_prot_byte_in = 8'hff, security_register_in = 0, rd;
   logic [15:0]  cmd_addr_in = 0;
   cmd_kind_type cmd_kind_in = CMD_NONE;
   logic         pready_out, pslverr_out, irq_out, key_write_mode_out;
   logic         cmd_accept_out, cmd_reject_out;
   int           miscompares = 0, n_tests = 0;
   always #4 mclk_in = ~mclk_in;
   flash_prot_cfg dut_u (.mclk_in, .rst_b_in, .psel_in, .penable_in,
      .pwrite_in, .paddr_in, .pwdata_in, .nvm_prot_byte_in,
      .security_register_in, .buffer_empty_set_in, .command_done_set_in,
      .cmd_valid_in, .cmd_kind_in, .cmd_addr_in, .pready_out, .prdata_out,
      .pslverr_out, .irq_out, .key_write_mode_out, .cmd_accept_out,
      .cmd_reject_out);
   task check(input logic [7:0] e, input logic [7:0] g);
      n_tests++;
      if (g !== e) begin
         miscompares++;
         $display("Error t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
      int n;
      @(posedge mclk_in);
      psel_in <= 1;
      pwrite_in <= w;
      paddr_in <= a;
      pwdata_in <= {24'h0, d};
      @(posedge mclk_in);
      penable_in <= 1;
      n = 0;
      do begin
         @(posedge mclk_in);
         n++;
      end while (pready_out !== 1'b1 && n < 20);
      if (n >= 20)
         miscompares++;
      rd = prdata_out[7:0];
      psel_in <= 0;
      penable_in <= 0;
   endtask
   task rdc(input logic [11:0] a, input logic [7:0] e);
      apb(0, a, 8'h00);
      check(e, rd);
   endtask
   // e is {accept, reject}
   task cmd(input cmd_kind_type k, input logic [15:0] a, input logic [1:0] e);
      @(posedge mclk_in);
      cmd_valid_in <= 1;
      cmd_kind_in <= k;
      cmd_addr_in <= a;
      @(posedge mclk_in);
      cmd_valid_in <= 0;
      #1 check({6'h0, e}, {6'h0, cmd_accept_out, cmd_reject_out});
   endtask
   task rst(input logic [7:0] v);
      rst_b_in <= 0;
      nvm_prot_byte_in <= v;
      repeat (3) @(posedge mclk_in);
      rst_b_in <= 1;
      repeat (2) @(posedge mclk_in);
   endtask
   task finish_test;
      $display("TB: tests=%0d miscompares=%0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      rst(8'hff);
      rdc(`PROT_OFFSET, 8'hff);
      cmd(CMD_PROGRAM, `NVM_PROT_ADDR, 2'b10);
      apb(1, `CFG_OFFSET, 8'hff);
      rdc(`CFG_OFFSET, 8'hc0);
      security_register_in <= 8'h80;
      apb(1, `CFG_OFFSET, 8'hff);
      rdc(`CFG_OFFSET, 8'he0);
      check(8'h01, {7'h0, key_write_mode_out});
      cmd(CMD_PROGRAM, 16'h8000, 2'b00);
      apb(1, `CFG_OFFSET, 8'h80);
      @(posedge mclk_in);
      buffer_empty_set_in <= 1;
      @(posedge mclk_in);
      buffer_empty_set_in <= 0;
      #1 check(8'h01, {7'h0, irq_out});
      apb(1, `STAT_OFFSET, 8'he0);
      #1 check(8'h00, {7'h0, irq_out});
      apb(1, `CFG_OFFSET, 8'h40);
      @(posedge mclk_in);
      command_done_set_in <= 1;
      @(posedge mclk_in);
      command_done_set_in <= 0;
      #1 check(8'h01, {7'h0, irq_out});
      apb(1, `CFG_OFFSET, 8'h00);
      #1 check(8'h00, {7'h0, irq_out});
      cmd(CMD_MASS_ERASE, 16'h4000, 2'b10);
      apb(1, `PROT_OFFSET, 8'he4);
      rdc(`PROT_OFFSET, 8'he4);
      apb(1, `PROT_OFFSET, 8'he1);
      rdc(`PROT_OFFSET, 8'he1);
      apb(1, `PROT_OFFSET, 8'he3);
      rdc(`PROT_OFFSET, 8'he1);
      cmd(CMD_PROGRAM, 16'h4000, 2'b01);
      cmd(CMD_SECT_ERASE, 16'h43fe, 2'b01);
      cmd(CMD_PROGRAM, 16'h4400, 2'b10);
      cmd(CMD_MASS_ERASE, 16'h8000, 2'b01);
      rdc(`STAT_OFFSET, 8'h60);
      apb(1, `PROT_OFFSET, 8'he4);
      rdc(`PROT_OFFSET, 8'he1);
      apb(1, `PROT_OFFSET, 8'hc1);
      rdc(`PROT_OFFSET, 8'hc1);
      apb(1, `PROT_OFFSET, 8'hd9);
      rdc(`PROT_OFFSET, 8'hc1);
      cmd(CMD_PROGRAM, 16'hf800, 2'b01);
      cmd(CMD_PROGRAM, 16'hf7fe, 2'b10);
      apb(1, `PROT_OFFSET, 8'h41);
      rdc(`PROT_OFFSET, 8'hc1);
      rst(8'h7f);
      cmd(CMD_PROGRAM, 16'h8000, 2'b01);
      rst(8'h7b);
      cmd(CMD_PROGRAM, 16'h4100, 2'b10);
      cmd(CMD_PROGRAM, 16'h8000, 2'b01);
      rdc(`CMD_OFFSET, 8'h00);
      check(8'h00, {7'h0, pslverr_out});
      finish_test;
   end
   // generous bound, normal run is under 150 cycles
   initial begin
      #200000;
      miscompares++;
      finish_test;
   end
endmodule
